// ### rtl/ubrg_top.sv
// Baud-rate generator: timer 1, timer 2 baud mode, fixed divisions and APB register file.
`timescale 1ns/1ps

// Notes on behaviour
// - Mode 0 bit clock is oscillator over 12.
// - Mode 2 rate osc/32, doubled by rate bit.
// - Modes 1 and 3 use timer overflows.
// - Timer 1 rate: overflow over 32, doubling option.
// - Timer 1 overflows every 12*(256-reload) cycles.
// - Timer 2 rate: overflow over 16, no doubling.
// - Timer 2 reloads only with both selects set.
// - Timer 2 overflow reloads whole 16-bit count.
// - Timer 2 counts oscillator divided by two.
// - Reload bytes form one unsigned 16-bit value.
// - Baud overflow never sets timer 2 flag.
// - Timer 2 counts clocks or external events.
// - In modes 1 and 3 each direction picks source from its select.
module ubrg_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic t2_event_pin_i,
  output logic [1:0] serial_mode_o,
  output logic tx_tick16_o,
  output logic rx_tick16_o,
  output logic mode0_bit_tick_o
);
  import ubrg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register file state.
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] t1_reload_byte_reg, t1_reload_byte_next;
  logic [7:0] t1_count_byte_reg, t1_count_byte_next;
  logic [7:0] t2_reload_high_reg, t2_reload_high_next;
  logic [7:0] t2_reload_low_reg, t2_reload_low_next;
  logic [15:0] t2_count_reg, t2_count_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  ////////////////////////////////////////////////////////////////////////////
  // Prescalers and rate dividers.
  logic [3:0] osc12_cnt_reg, osc12_cnt_next;
  logic osc2_cnt_reg, osc2_cnt_next;
  logic mode2_cnt_reg, mode2_cnt_next;
  logic t1_half_reg, t1_half_next;
  logic [1:0] ev_sync_reg, ev_sync_next;
  logic ev_prev_reg, ev_prev_next;
  logic tx_tick_reg, tx_tick_next;
  logic rx_tick_reg, rx_tick_next;
  logic m0_tick_reg, m0_tick_next;
  logic [1:0] mode_reg, mode_next;

  logic osc12_pulse, osc2_pulse, ev_pulse, t2_inc, t1_ovf, t2_ovf, t1_tick16, t2_tick16, m2_tick16;
  logic baud_mode, acc_wr, acc_rd;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == UBRG_CTRL_OFFS) || (a == UBRG_T1_OFFS) || (a == UBRG_T2_RELOAD_OFFS) ||
                (a == UBRG_T2_COUNT_OFFS) || (a == UBRG_STATUS_OFFS);
  endfunction

  assign acc_wr = psel_i && penable_i && pwrite_i && !pready_reg;
  assign acc_rd = psel_i && penable_i && !pwrite_i && !pready_reg;
  assign baud_mode = ctrl_reg[UBRG_TX_CLOCK_SELECT_POS] && ctrl_reg[UBRG_RX_CLOCK_SELECT_POS];

  assign osc12_pulse = (osc12_cnt_reg == 4'(UBRG_MODE0_DIV - 1));
  assign osc2_pulse = osc2_cnt_reg;
  assign ev_pulse = ev_prev_reg && !ev_sync_reg[1];
  assign t2_inc = ctrl_reg[UBRG_T2_RUN_POS] &&
                  (ctrl_reg[UBRG_T2_COUNTER_SELECT_POS] ? ev_pulse : osc2_pulse);
  assign t1_ovf = ctrl_reg[UBRG_T1_RUN_POS] && osc12_pulse && (t1_count_byte_reg == 8'hff);
  assign t2_ovf = t2_inc && (t2_count_reg == 16'hffff);
  // Timer 1 overflow over 32 is a 16x tick every other overflow unless doubled.
  assign t1_tick16 = t1_ovf && (ctrl_reg[UBRG_RATE_DOUBLE_POS] || t1_half_reg);
  assign t2_tick16 = t2_ovf;
  assign m2_tick16 = ctrl_reg[UBRG_RATE_DOUBLE_POS] || mode2_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    ctrl_next = ctrl_reg;
    t1_reload_byte_next = t1_reload_byte_reg;
    t1_count_byte_next = t1_count_byte_reg;
    t2_reload_high_next = t2_reload_high_reg;
    t2_reload_low_next = t2_reload_low_reg;
    t2_count_next = t2_count_reg;
    prdata_next = prdata_reg;
    pready_next = psel_i && penable_i && !pready_reg;
    pslverr_next = 1'b0;
    osc12_cnt_next = osc12_pulse ? 4'h0 : osc12_cnt_reg + 4'h1;
    osc2_cnt_next = ~osc2_cnt_reg;
    mode2_cnt_next = ~mode2_cnt_reg;
    t1_half_next = t1_ovf ? ~t1_half_reg : t1_half_reg;
    ev_sync_next = {ev_sync_reg[0], t2_event_pin_i};
    ev_prev_next = ev_sync_reg[1];
    mode_next = ctrl_reg[UBRG_MODE_LSB +: 2];

    // Timer 1 in 8-bit auto-reload: count byte reloads from the reload byte.
    if (ctrl_reg[UBRG_T1_RUN_POS] && osc12_pulse) begin
      t1_count_byte_next = t1_ovf ? t1_reload_byte_reg : t1_count_byte_reg + 8'h01;
    end
    // Timer 2 in baud mode: overflow reloads 16 bits; no overflow flag exists here.
    if (t2_inc) begin
      t2_count_next = (t2_ovf && baud_mode) ? {t2_reload_high_reg, t2_reload_low_reg}
                                            : t2_count_reg + 16'h0001;
    end

    if (acc_wr) begin
      if (!is_mapped(paddr_i)) begin
        pslverr_next = 1'b1;
      end
      case (paddr_i)
        UBRG_CTRL_OFFS: ctrl_next = pwdata_i[7:0];
        UBRG_T1_OFFS: begin
          t1_reload_byte_next = pwdata_i[15:8];
          t1_count_byte_next = pwdata_i[7:0];
        end
        UBRG_T2_RELOAD_OFFS: begin
          t2_reload_high_next = pwdata_i[15:8];
          t2_reload_low_next = pwdata_i[7:0];
        end
        UBRG_T2_COUNT_OFFS: t2_count_next = pwdata_i[15:0];
        default: ;
      endcase
    end
    if (acc_rd) begin
      pslverr_next = !is_mapped(paddr_i);
      case (paddr_i)
        UBRG_CTRL_OFFS: prdata_next = {24'h000000, ctrl_reg};
        UBRG_T1_OFFS: prdata_next = {16'h0000, t1_reload_byte_reg, t1_count_byte_reg};
        UBRG_T2_RELOAD_OFFS: prdata_next = {16'h0000, t2_reload_high_reg, t2_reload_low_reg};
        UBRG_T2_COUNT_OFFS: prdata_next = {16'h0000, t2_count_reg};
        UBRG_STATUS_OFFS: prdata_next = {29'h00000000, baud_mode, t1_half_reg, mode2_cnt_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end

    // Each direction picks its 16x tick from the mode and its own select bit.
    m0_tick_next = 1'b0;
    tx_tick_next = 1'b0;
    rx_tick_next = 1'b0;
    case (ubrg_mode_t'(ctrl_reg[UBRG_MODE_LSB +: 2]))
      UBRG_MODE_SHIFT: m0_tick_next = osc12_pulse;
      UBRG_MODE_9BIT_FIXED: begin
        tx_tick_next = m2_tick16;
        rx_tick_next = m2_tick16;
      end
      UBRG_MODE_8BIT_VAR, UBRG_MODE_9BIT_VAR: begin
        tx_tick_next = ctrl_reg[UBRG_TX_CLOCK_SELECT_POS] ? t2_tick16 : t1_tick16;
        rx_tick_next = ctrl_reg[UBRG_RX_CLOCK_SELECT_POS] ? t2_tick16 : t1_tick16;
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= UBRG_CTRL_RESET;
      t1_reload_byte_reg <= UBRG_BYTE_RESET;
      t1_count_byte_reg <= UBRG_BYTE_RESET;
      t2_reload_high_reg <= UBRG_BYTE_RESET;
      t2_reload_low_reg <= UBRG_BYTE_RESET;
      t2_count_reg <= UBRG_WORD_RESET;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      osc12_cnt_reg <= 4'h0;
      osc2_cnt_reg <= 1'b0;
      mode2_cnt_reg <= 1'b0;
      t1_half_reg <= 1'b0;
      ev_sync_reg <= 2'h0;
      ev_prev_reg <= 1'b0;
      tx_tick_reg <= 1'b0;
      rx_tick_reg <= 1'b0;
      m0_tick_reg <= 1'b0;
      mode_reg <= 2'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      t1_reload_byte_reg <= t1_reload_byte_next;
      t1_count_byte_reg <= t1_count_byte_next;
      t2_reload_high_reg <= t2_reload_high_next;
      t2_reload_low_reg <= t2_reload_low_next;
      t2_count_reg <= t2_count_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      osc12_cnt_reg <= osc12_cnt_next;
      osc2_cnt_reg <= osc2_cnt_next;
      mode2_cnt_reg <= mode2_cnt_next;
      t1_half_reg <= t1_half_next;
      ev_sync_reg <= ev_sync_next;
      ev_prev_reg <= ev_prev_next;
      tx_tick_reg <= tx_tick_next;
      rx_tick_reg <= rx_tick_next;
      m0_tick_reg <= m0_tick_next;
      mode_reg <= mode_next;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign tx_tick16_o = tx_tick_reg;
  assign rx_tick16_o = rx_tick_reg;
  assign mode0_bit_tick_o = m0_tick_reg;
  assign serial_mode_o = mode_reg;

endmodule

// ### rtl/ubrg_pkg.sv
// Package with register map, field positions and constants of the baud-rate generator.
package ubrg_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] UBRG_CTRL_OFFS = 8'h00;
  localparam logic [7:0] UBRG_T1_OFFS = 8'h04;
  localparam logic [7:0] UBRG_T2_RELOAD_OFFS = 8'h08;
  localparam logic [7:0] UBRG_T2_COUNT_OFFS = 8'h0c;
  localparam logic [7:0] UBRG_STATUS_OFFS = 8'h10;

  // Field positions in the control register.
  localparam int UBRG_MODE_LSB = 0;
  localparam int UBRG_RATE_DOUBLE_POS = 2;
  localparam int UBRG_TX_CLOCK_SELECT_POS = 3;
  localparam int UBRG_RX_CLOCK_SELECT_POS = 4;
  localparam int UBRG_T1_RUN_POS = 5;
  localparam int UBRG_T2_RUN_POS = 6;
  localparam int UBRG_T2_COUNTER_SELECT_POS = 7;

  // Values after reset.
  localparam logic [7:0] UBRG_CTRL_RESET = 8'h00;
  localparam logic [7:0] UBRG_BYTE_RESET = 8'h00;
  localparam logic [15:0] UBRG_WORD_RESET = 16'h0000;

  // Fixed divisions of the oscillator.
  localparam int UBRG_MODE0_DIV = 12;
  localparam int UBRG_T1_PRESCALE = 12;
  localparam int UBRG_T2_PRESCALE = 2;
  localparam int UBRG_MODE2_SAMPLE_DIV = 2;
  localparam logic [3:0] UBRG_OVERSAMPLE_LAST = 4'hf;

  typedef enum logic [1:0] {
    UBRG_MODE_SHIFT,
    UBRG_MODE_8BIT_VAR,
    UBRG_MODE_9BIT_FIXED,
    UBRG_MODE_9BIT_VAR
  } ubrg_mode_t;

endpackage

// ### dv/ubrg_properties.sv
// Checker of bus handshake and tick spacing of the baud-rate generator.
`timescale 1ns/1ps
module ubrg_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [1:0] serial_mode_o,
  input wire logic tx_tick16_o,
  input wire logic rx_tick16_o,
  input wire logic mode0_bit_tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("no ready");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i)) else $error("stray ready");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  a_unmapped_zero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0) else $error("bad read");
  a_mode0_spacing: assert property (disable iff (!rst_n_i || serial_mode_o != 2'h0)
    mode0_bit_tick_o |=> !mode0_bit_tick_o [*8] ##1 !mode0_bit_tick_o [*3] ##1 mode0_bit_tick_o)
    else $error("mode 0 tick spacing");
  a_mode0_only: assert property (
    serial_mode_o != 2'h0 && $past(serial_mode_o) != 2'h0 && $past(serial_mode_o, 2) != 2'h0
    |-> !mode0_bit_tick_o) else $error("mode 0 tick in other mode");
  a_no_tick16: assert property (
    serial_mode_o == 2'h0 && $past(serial_mode_o) == 2'h0 |-> !tx_tick16_o && !rx_tick16_o)
    else $error("tick16 in mode 0");
  a_mode2_gap: assert property (disable iff (!rst_n_i || serial_mode_o != 2'h2)
    tx_tick16_o && rx_tick16_o && $past(serial_mode_o) == 2'h2 |=> ##[0:1] tx_tick16_o)
    else $error("mode 2 tick gap");
  cover property (pready_o && pslverr_o);
  cover property (serial_mode_o == 2'h3 && rx_tick16_o);
  cover property (mode0_bit_tick_o);
endmodule

bind ubrg_top ubrg_properties i_ubrg_properties (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .serial_mode_o(serial_mode_o), .tx_tick16_o(tx_tick16_o),
  .rx_tick16_o(rx_tick16_o), .mode0_bit_tick_o(mode0_bit_tick_o));

// ### dv/ubrg_uart_model.sv
// Bit-timing consumer that records the spacing of the generator's tick pulses.
`timescale 1ns/1ps
module ubrg_uart_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] tick_i,
  output logic [31:0] gap_o [3],
  output logic [31:0] cnt_o [3]
);
  logic [31:0] age_reg [3];
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 3; k++) begin
      if (!rst_n_i) begin
        age_reg[k] <= 32'h0;
        gap_o[k] <= 32'h0;
        cnt_o[k] <= 32'h0;
      end else if (tick_i[k]) begin
        gap_o[k] <= age_reg[k] + 32'h1;
        age_reg[k] <= 32'h0;
        cnt_o[k] <= cnt_o[k] + 32'h1;
      end else begin
        age_reg[k] <= age_reg[k] + 32'h1;
      end
    end
  end
endmodule

// ### dv/tb.sv
// Testbench driving the baud-rate generator over APB and timing its ticks.
`timescale 1ns/1ps
module tb;
  import ubrg_pkg::*;
  logic clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0, pin = 1, pin_run = 0, er;
  logic pready, pslverr, tx, rx, m0;
  logic [1:0] mode, pdiv = 2'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [31:0] gap [3], cnt [3];
  int err_total = 0, samples_checked = 0;
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    pdiv <= pdiv + 2'h1;
    if (pin_run && &pdiv) pin <= ~pin;
  end
  ubrg_top i_ubrg_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .t2_event_pin_i(pin), .serial_mode_o(mode), .tx_tick16_o(tx),
    .rx_tick16_o(rx), .mode0_bit_tick_o(m0));
  ubrg_uart_model i_ubrg_uart_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .tick_i({m0, rx, tx}),
    .gap_o(gap), .cnt_o(cnt));
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    if (n >= 20) report_and_stop();
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task measure(input int k, input logic [31:0] exp);
    logic [31:0] c0;
    int n;
    c0 = cnt[k];
    n = 0;
    while (cnt[k] - c0 < 3 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000) err_total++;
    if (n >= 2000) report_and_stop();
    check(gap[k], exp);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, UBRG_CTRL_OFFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check({rd[31:1], er}, 32'h1);
    measure(2, 12);
    check({30'h0, mode}, 32'h0);
    apb(1'b1, UBRG_CTRL_OFFS, 32'h02);
    measure(0, 2);
    apb(1'b1, UBRG_CTRL_OFFS, 32'h06);
    measure(1, 1);
    $display("test fixed_rates done");
    apb(1'b1, UBRG_T1_OFFS, 32'hfefe);
    apb(1'b1, UBRG_CTRL_OFFS, 32'h21);
    measure(0, 48);
    check({30'h0, mode}, 32'h1);
    apb(1'b1, UBRG_CTRL_OFFS, 32'h25);
    measure(1, 24);
    $display("test timer1 done");
    apb(1'b1, UBRG_T2_RELOAD_OFFS, 32'hfffd);
    apb(1'b1, UBRG_T2_COUNT_OFFS, 32'hfffd);
    apb(1'b1, UBRG_CTRL_OFFS, 32'h5b);
    measure(0, 6);
    apb(1'b1, UBRG_CTRL_OFFS, 32'h5f);
    measure(1, 6);
    apb(1'b0, UBRG_STATUS_OFFS, 32'h0);
    check(rd & 32'h4, 32'h4);
    apb(1'b1, UBRG_CTRL_OFFS, 32'h23);
    measure(1, 48);
    check({30'h0, mode}, 32'h3);
    apb(1'b1, UBRG_T2_COUNT_OFFS, 32'hfffd);
    pin_run <= 1'b1;
    apb(1'b1, UBRG_CTRL_OFFS, 32'hdb);
    measure(0, 24);
    $display("test timer2 done");
    report_and_stop();
  end
endmodule
